// >>> common/afs_pkg.sv
// constants for the amplifier fault status and mask bank
package afs_pkg;
   // register offsets
   localparam logic [7:0] AFS_OFS_CHAN = 8'h70;
   localparam logic [7:0] AFS_OFS_GLOB_A = 8'h71;
   localparam logic [7:0] AFS_OFS_GLOB_B = 8'h72;
   localparam logic [7:0] AFS_OFS_WARN = 8'h73;
   localparam logic [7:0] AFS_OFS_MASK = 8'h74;
   localparam logic [7:0] AFS_OFS_LATCH = 8'h75;
   localparam logic [7:0] AFS_OFS_CLEAR = 8'h78;
   // reset values
   localparam logic [7:0] AFS_RST_STATUS = 8'h00;
   localparam logic [7:0] AFS_RST_MASK = 8'h00;
   localparam logic [7:0] AFS_RST_LATCH = 8'hF8;
   // writable bits of the mask register, bit 3 reads zero
   localparam logic [7:0] AFS_MASK_WMASK = 8'hF7;
   // fault report mask bit positions
   localparam int AFS_M_OTSD = 7;
   localparam int AFS_M_DVDD_UV = 6;
   localparam int AFS_M_DVDD_OV = 5;
   localparam int AFS_M_CLK = 4;
   localparam int AFS_M_PVDD = 2;
   localparam int AFS_M_DC = 1;
   localparam int AFS_M_OC = 0;
   // latch enable register bit positions
   localparam int AFS_L_CBC_FAULT = 7;
   localparam int AFS_L_CBC_WARN = 6;
   localparam int AFS_L_CLK = 5;
   localparam int AFS_L_OTSD = 4;
   localparam int AFS_L_OTW = 3;
   localparam int AFS_L_MASK_OTW = 2;
   localparam int AFS_L_MASK_CBCW = 1;
   localparam int AFS_L_MASK_CBC = 0;
   // fault clear bit
   localparam int AFS_CLR_ANALOG = 7;
   // index of each asynchronous condition in the internal vector
   localparam int AFS_I_R_OC = 0;
   localparam int AFS_I_L_OC = 1;
   localparam int AFS_I_R_DC = 2;
   localparam int AFS_I_L_DC = 3;
   localparam int AFS_I_PVDD_UV = 4;
   localparam int AFS_I_PVDD_OV = 5;
   localparam int AFS_I_CLK = 6;
   localparam int AFS_I_OTSD = 7;
   localparam int AFS_I_L_CBC = 8;
   localparam int AFS_I_R_CBC = 9;
   localparam int AFS_I_L_CBCW = 10;
   localparam int AFS_I_R_CBCW = 11;
   localparam int AFS_I_OTW_A = 12;
   localparam int AFS_I_OTW_B = 13;
   localparam int AFS_I_OTW_C = 14;
   localparam int AFS_I_OTW_D = 15;
   localparam int AFS_I_DVDD_UV = 16;
   localparam int AFS_I_DVDD_OV = 17;
   localparam int AFS_NUM_IN = 18;
   // synchroniser depth
   localparam int AFS_SYNC_STAGES = 3;
endpackage

// >>> hdl/afs_bank.sv
// fault, warning and report mask register bank
// What this block does
// - DC faults in channel bits 3, 2
// - over-current faults in channel bits 1, 0
// - memory checksum error sets global A bit 7
// - failed coefficient write sets global A bit 6
// - boot load outcome in global A bit 5
// - cycle limit faults in global B bits 2, 1
// - shutdown in global B bit 0, rest zero
// - cycle limit warnings in warning bits 5, 4
// - four temperature warning levels in bits 0-3
// - mask bit 7 hides shutdown report
// - mask bits 6, 5 hide digital supply reports
// - mask bit 4 hides clock fault report
// - mask bit 2 hides power supply reports
// - mask bits 1, 0 hide DC, over-current
// - clear bit 7 clears latched analog faults
// - latch enables, bits 7 to 3 set at reset
module afs_bank
   import afs_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // register port of the control bus
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // asynchronous analog conditions, active high
   input wire logic left_overcurrent_flag,
   input wire logic right_overcurrent_flag,
   input wire logic left_dc_fault_flag,
   input wire logic right_dc_fault_flag,
   input wire logic power_supply_under_flag,
   input wire logic power_supply_over_flag,
   input wire logic clock_fault_flag,
   input wire logic overtemp_shutdown_flag,
   input wire logic left_cycle_limit_fault,
   input wire logic right_cycle_limit_fault,
   input wire logic left_cycle_limit_warning,
   input wire logic right_cycle_limit_warning,
   input wire logic overtemp_warn_level_a,
   input wire logic overtemp_warn_level_b,
   input wire logic overtemp_warn_level_c,
   input wire logic overtemp_warn_level_d,
   input wire logic digital_supply_under_flag,
   input wire logic digital_supply_over_flag,
   // conditions from on-chip digital logic, same clock
   input wire logic otp_checksum_error,
   input wire logic coef_write_error,
   input wire logic boot_load_error,
   // fault and warning report outputs, active low
   output logic fault_report_n,
   output logic warn_report_n
);

   // timing of a fault input, counted in clock edges after it changes:
   //    edge 1  first stage takes the new level
   //    edge 2  second stage
   //    edge 3  third stage
   //    edge 4  stages two and three agree, live level changes
   //    edge 5  status bit set
   //    edge 6  report output changes, edge 5 for digital supply
   // timing of the register port:
   //    read    strobe taken at an edge, answer and valid loaded at that same edge
   //    write   register updated at the edge that takes the strobe
   //    clear   latched bits drop at that edge when the level is gone
   //    report  follows one edge after the status bits
   // latching summary:
   //    dc, over-current, power supply  always latched
   //    clock, cycle limit, shutdown    latched when enabled
   //    temperature warnings            latched when enabled
   //    memory, coefficient, boot       never latched
   //    digital supply                  no status bit at all
   // masking never changes a status bit, only the report
   // writes to the status offsets change nothing
   // all status and mask bits clear at reset

   // the whole bank lives in one packed state word
   // synchroniser stages, live levels, six registers,
   // the read answer and the two report outputs
   // everything moves on every clock edge, no enables
   typedef struct packed {
      // first stage, may go metastable, read only by stage two
      logic [AFS_NUM_IN-1:0] sync_a;
      // second and third stages, compared to filter one-edge blips
      logic [AFS_NUM_IN-1:0] sync_b;
      logic [AFS_NUM_IN-1:0] sync_c;
      // filtered levels, change only when stages two and three agree
      logic [AFS_NUM_IN-1:0] live;
      // status registers as seen by the host
      logic [7:0] chan;
      logic [7:0] glob_a;
      logic [7:0] glob_b;
      logic [7:0] warn;
      // host-written mask and latch enable registers
      logic [7:0] mask;
      logic [7:0] latch_en;
      // registered read answer and valid pulse
      logic [7:0] rdata;
      logic rvalid;
      // registered report levels, active low
      logic fault_n;
      logic warn_n;
   } afs_state_t;

   // cur is the registered state, next_st its next value
   afs_state_t cur;
   afs_state_t next_st;

   // raw_in gathers the asynchronous pins in index order
   logic [AFS_NUM_IN-1:0] raw_in;

   // sticky when enabled: a live condition always wins over a clear
   // a set condition always wins over a clear in the same cycle,
   // so a clear written while the fault is still present is lost;
   // the host must clear again once the condition has gone
   function automatic logic hold_bit(input logic live, input logic prev, input logic en, input logic clr);
      hold_bit = live | (prev & en & ~clr);
   endfunction

   // one decode for every host write to a given offset
   function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
      wr_hit = wr && (a == ofs);
   endfunction

   // gather asynchronous conditions into one vector
   // fixed mapping keeps the index constants in one place
   // the vector is only ever read by the first stage
   always_comb
   begin
      raw_in = '0;
      raw_in[AFS_I_R_OC] = right_overcurrent_flag;
      raw_in[AFS_I_L_OC] = left_overcurrent_flag;
      raw_in[AFS_I_R_DC] = right_dc_fault_flag;
      raw_in[AFS_I_L_DC] = left_dc_fault_flag;
      raw_in[AFS_I_PVDD_UV] = power_supply_under_flag;
      raw_in[AFS_I_PVDD_OV] = power_supply_over_flag;
      raw_in[AFS_I_CLK] = clock_fault_flag;
      raw_in[AFS_I_OTSD] = overtemp_shutdown_flag;
      raw_in[AFS_I_L_CBC] = left_cycle_limit_fault;
      raw_in[AFS_I_R_CBC] = right_cycle_limit_fault;
      raw_in[AFS_I_L_CBCW] = left_cycle_limit_warning;
      raw_in[AFS_I_R_CBCW] = right_cycle_limit_warning;
      raw_in[AFS_I_OTW_A] = overtemp_warn_level_a;
      raw_in[AFS_I_OTW_B] = overtemp_warn_level_b;
      raw_in[AFS_I_OTW_C] = overtemp_warn_level_c;
      raw_in[AFS_I_OTW_D] = overtemp_warn_level_d;
      raw_in[AFS_I_DVDD_UV] = digital_supply_under_flag;
      raw_in[AFS_I_DVDD_OV] = digital_supply_over_flag;
   end

   // next state: synchroniser, host writes, status, reports, read
   // written as one process so that every field has one driver
   always_comb
   begin
      logic clr;
      logic [AFS_NUM_IN-1:0] lv;
      logic [7:0] m;
      logic [7:0] le;
      logic fault_any;
      logic warn_any;
      clr = 1'b0;
      lv = '0;
      m = '0;
      le = '0;
      fault_any = 1'b0;
      warn_any = 1'b0;
      next_st = cur;
      // three-stage synchroniser, a change counts once stages two and three agree
      // a one-edge blip, which is never in stages two and three at once,
      // never becomes live, so short glitches on the analog side
      // cannot latch a fault; the cost is four edges of delay
      // live holds its old level while stages two and three disagree
      next_st.sync_a = raw_in;
      next_st.sync_b = cur.sync_a;
      next_st.sync_c = cur.sync_b;
      for (int i = 0; i < AFS_NUM_IN; i++)
      begin
         if (cur.sync_b[i] == cur.sync_c[i])
         begin
            next_st.live[i] = cur.sync_c[i];
         end
      end
      lv = cur.live;
      m = cur.mask;
      le = cur.latch_en;
      // write-only clear pulse, never stored
      // the clear bit is never stored, so it reads back as zero
      // and a second write is needed for a fault still present
      clr = wr_hit(reg_wr, reg_addr, AFS_OFS_CLEAR) && reg_wdata[AFS_CLR_ANALOG];
      // writable registers; status writes fall through and are ignored
      // mask bit 3 is reserved and is forced to zero on write
      // the latch enable register keeps all eight bits
      if (wr_hit(reg_wr, reg_addr, AFS_OFS_MASK))
      begin
         next_st.mask = reg_wdata & AFS_MASK_WMASK;
      end
      if (wr_hit(reg_wr, reg_addr, AFS_OFS_LATCH))
      begin
         next_st.latch_en = reg_wdata;
      end
      // channel faults, always latched until cleared
      // these have no latch enable, they always hold until cleared
      next_st.chan = AFS_RST_STATUS;
      next_st.chan[3] = hold_bit(lv[AFS_I_L_DC], cur.chan[3], 1'b1, clr);
      next_st.chan[2] = hold_bit(lv[AFS_I_R_DC], cur.chan[2], 1'b1, clr);
      next_st.chan[1] = hold_bit(lv[AFS_I_L_OC], cur.chan[1], 1'b1, clr);
      next_st.chan[0] = hold_bit(lv[AFS_I_R_OC], cur.chan[0], 1'b1, clr);
      // global A: digital errors follow their sources, power supply latches, clock latches when enabled
      // memory, coefficient and boot errors are level copies of
      // same-clock sources, so they need no synchroniser and no clear
      next_st.glob_a = AFS_RST_STATUS;
      next_st.glob_a[7] = otp_checksum_error;
      next_st.glob_a[6] = coef_write_error;
      next_st.glob_a[5] = boot_load_error;
      next_st.glob_a[2] = hold_bit(lv[AFS_I_CLK], cur.glob_a[2], le[AFS_L_CLK], clr);
      next_st.glob_a[1] = hold_bit(lv[AFS_I_PVDD_OV], cur.glob_a[1], 1'b1, clr);
      next_st.glob_a[0] = hold_bit(lv[AFS_I_PVDD_UV], cur.glob_a[0], 1'b1, clr);
      // global B, bits 7..3 stay zero
      // cycle limit and shutdown latch only while enabled
      next_st.glob_b = AFS_RST_STATUS;
      next_st.glob_b[2] = hold_bit(lv[AFS_I_R_CBC], cur.glob_b[2], le[AFS_L_CBC_FAULT], clr);
      next_st.glob_b[1] = hold_bit(lv[AFS_I_L_CBC], cur.glob_b[1], le[AFS_L_CBC_FAULT], clr);
      next_st.glob_b[0] = hold_bit(lv[AFS_I_OTSD], cur.glob_b[0], le[AFS_L_OTSD], clr);
      // warnings
      // with the latch enable low the bits follow the live level
      next_st.warn = AFS_RST_STATUS;
      next_st.warn[5] = hold_bit(lv[AFS_I_L_CBCW], cur.warn[5], le[AFS_L_CBC_WARN], clr);
      next_st.warn[4] = hold_bit(lv[AFS_I_R_CBCW], cur.warn[4], le[AFS_L_CBC_WARN], clr);
      next_st.warn[3] = hold_bit(lv[AFS_I_OTW_D], cur.warn[3], le[AFS_L_OTW], clr);
      next_st.warn[2] = hold_bit(lv[AFS_I_OTW_C], cur.warn[2], le[AFS_L_OTW], clr);
      next_st.warn[1] = hold_bit(lv[AFS_I_OTW_B], cur.warn[1], le[AFS_L_OTW], clr);
      next_st.warn[0] = hold_bit(lv[AFS_I_OTW_A], cur.warn[0], le[AFS_L_OTW], clr);
      // report gating only; status bits above are never masked
      // the fault report sums every unmasked analog fault source;
      // digital supply conditions have no status bit and
      // feed only this report, straight from the live level
      // the cycle limit report mask lives in the latch register
      // shutdown, clock, power supply, dc and over-current use the
      // status bits, so a report stays until the host clears, for shutdown and clock only while latched
      fault_any = (cur.glob_b[0] & ~m[AFS_M_OTSD])
         | (lv[AFS_I_DVDD_UV] & ~m[AFS_M_DVDD_UV])
         | (lv[AFS_I_DVDD_OV] & ~m[AFS_M_DVDD_OV])
         | (cur.glob_a[2] & ~m[AFS_M_CLK])
         | ((cur.glob_a[1] | cur.glob_a[0]) & ~m[AFS_M_PVDD])
         | ((cur.chan[3] | cur.chan[2]) & ~m[AFS_M_DC])
         | ((cur.chan[1] | cur.chan[0]) & ~m[AFS_M_OC])
         | ((cur.glob_b[2] | cur.glob_b[1]) & ~le[AFS_L_MASK_CBC]);
      // warnings are masked by bits of the latch register
      warn_any = ((cur.warn[5] | cur.warn[4]) & ~le[AFS_L_MASK_CBCW])
         | ((|cur.warn[3:0]) & ~le[AFS_L_MASK_OTW]);
      next_st.fault_n = ~fault_any;
      next_st.warn_n = ~warn_any;
      // registered read answer, unmapped offsets read zero
      // the answer stands until the next read; valid is one pulse
      // a read and a write in the same cycle return the old value
      next_st.rvalid = reg_rd;
      if (reg_rd)
      begin
         // unmapped offsets, including the clear register, read zero
         case (reg_addr)
            AFS_OFS_CHAN: next_st.rdata = cur.chan;
            AFS_OFS_GLOB_A: next_st.rdata = cur.glob_a;
            AFS_OFS_GLOB_B: next_st.rdata = cur.glob_b;
            AFS_OFS_WARN: next_st.rdata = cur.warn;
            AFS_OFS_MASK: next_st.rdata = cur.mask;
            AFS_OFS_LATCH: next_st.rdata = cur.latch_en;
            default: next_st.rdata = 8'h00;
         endcase
      end
   end

   // state register, cleared at reset except latch enables and reports
   // the reset branch loads constants only
   // report outputs idle high, latch enables idle with bits 7 to 3 set
   // the struct is cleared as a whole, then fields with nonzero
   // reset values are overridden; later assignments win
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cur <= '0;
         cur.mask <= AFS_RST_MASK;
         cur.latch_en <= AFS_RST_LATCH;
         cur.fault_n <= 1'b1;
         cur.warn_n <= 1'b1;
      end
      else
      begin
         cur <= next_st;
      end
   end

   // outputs straight from flip-flops
   // no logic between the state register and the pins
   assign reg_rdata = cur.rdata;
   assign reg_rvalid = cur.rvalid;
   assign fault_report_n = cur.fault_n;
   assign warn_report_n = cur.warn_n;

endmodule

// >>> tb/afs_bank_chk.sv
// port checker for the fault status and mask bank
module afs_bank_chk
   import afs_pkg::*;
(
   // clock, reset and register port
   input wire logic clk_sys, sys_rst, reg_wr, reg_rd, reg_rvalid,
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
   // watched conditions and reports
   input wire logic left_overcurrent_flag, left_dc_fault_flag, overtemp_warn_level_a,
   input wire logic fault_report_n, warn_report_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh_mask;
   logic [7:0] sh_lat;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // shadows of the host-written mask registers
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sh_mask <= AFS_RST_MASK;
         sh_lat <= AFS_RST_LATCH;
      end
      else if (reg_wr && reg_addr == AFS_OFS_MASK)
         sh_mask <= reg_wdata & AFS_MASK_WMASK;
      else if (reg_wr && reg_addr == AFS_OFS_LATCH)
         sh_lat <= reg_wdata;
   end
   a_rvalid_follows: assert property (reg_rd |=> reg_rvalid)
      else $error("read gave no valid pulse");
   a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("valid pulse without read");
   a_chan_reserved: assert property (reg_rvalid && $past(reg_addr) == AFS_OFS_CHAN |-> reg_rdata[7:4] == 4'h0)
      else $error("channel upper bits set");
   a_globb_reserved: assert property (reg_rvalid && $past(reg_addr) == AFS_OFS_GLOB_B |-> reg_rdata[7:3] == 5'h00)
      else $error("global b upper bits set");
   a_warn_reserved: assert property (reg_rvalid && $past(reg_addr) == AFS_OFS_WARN |-> reg_rdata[7:6] == 2'h0)
      else $error("warning upper bits set");
   a_mask_readback: assert property (reg_rvalid && $past(reg_addr) == AFS_OFS_MASK |-> reg_rdata == $past(sh_mask))
      else $error("mask readback wrong");
   a_unmapped_zero: assert property (reg_rvalid && !($past(reg_addr) inside {[8'h70:8'h75]}) |-> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_oc_report: assert property ((left_overcurrent_flag && !sh_mask[AFS_M_OC])[*8] |-> !fault_report_n)
      else $error("over-current not reported");
   a_otw_report: assert property ((overtemp_warn_level_a && !sh_lat[AFS_L_MASK_OTW])[*8] |-> !warn_report_n)
      else $error("warning not reported");
   a_dc_status: assert property (left_dc_fault_flag[*7] ##1 (reg_rd && reg_addr == AFS_OFS_CHAN) |=> reg_rdata[3])
      else $error("dc fault not recorded");
   c_masked_dc: cover property (left_dc_fault_flag && sh_mask[AFS_M_DC] && fault_report_n);
   c_mask_read: cover property (reg_rvalid && $past(reg_addr) == AFS_OFS_MASK);
   c_warn_seen: cover property (!warn_report_n);
endmodule
bind afs_bank afs_bank_chk u_chk (.*);

// >>> tb/afs_host.sv
// host model driving the register port of the bank
module afs_host (
   // clock
   input wire logic clk_sys,
   // register port
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
   // one strobe held to its sampling edge, then released
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= wr;
      reg_rd <= !wr;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask
endmodule

// >>> tb/tb_afs_bank.sv
// self-checking bench for the fault status and mask bank
module tb_afs_bank
   import afs_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rnd;
   logic reg_wr, reg_rd, reg_rvalid, fault_report_n, warn_report_n;
   logic [17:0] flt = '0;
   logic [2:0] dig = 3'h0;
   logic [15:0] loc;
   logic [7:0] exp_q[$];
   int mismatches = 0;
   int checked = 0;
   int cyc = 0;
   afs_host u_host (.*);
   afs_bank u_dut (.*, .right_overcurrent_flag(flt[0]), .left_overcurrent_flag(flt[1]),
      .right_dc_fault_flag(flt[2]), .left_dc_fault_flag(flt[3]), .power_supply_under_flag(flt[4]),
      .power_supply_over_flag(flt[5]), .clock_fault_flag(flt[6]), .overtemp_shutdown_flag(flt[7]),
      .left_cycle_limit_fault(flt[8]), .right_cycle_limit_fault(flt[9]), .left_cycle_limit_warning(flt[10]),
      .right_cycle_limit_warning(flt[11]), .overtemp_warn_level_a(flt[12]), .overtemp_warn_level_b(flt[13]),
      .overtemp_warn_level_c(flt[14]), .overtemp_warn_level_d(flt[15]), .digital_supply_under_flag(flt[16]),
      .digital_supply_over_flag(flt[17]), .otp_checksum_error(dig[2]), .coef_write_error(dig[1]),
      .boot_load_error(dig[0]));
   initial forever #5 clk_sys = ~clk_sys;
   // compare one value and count it
   task automatic chk(input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_host.access(1'b0, a, 8'h00);
   endtask
   task automatic finish_test();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // register offset and bit that record condition i
   function automatic logic [15:0] where(input int i);
      if (i < 4)
         return {AFS_OFS_CHAN, 8'h01 << i};
      if (i < 7)
         return {AFS_OFS_GLOB_A, 8'h01 << (i - 4)};
      if (i < 10)
         return {AFS_OFS_GLOB_B, 8'h01 << (i - 7)};
      if (i < 12)
         return {AFS_OFS_WARN, 8'h20 >> (i - 10)};
      return {AFS_OFS_WARN, 8'h01 << (i - 12)};
   endfunction
   // read answers paired with the oldest note
   always @(posedge clk_sys)
   begin
      if (reg_rvalid === 1'b1)
         chk(exp_q.pop_front(), reg_rdata);
   end
   // hang guard
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         mismatches++;
         finish_test();
      end
   end
   // main sequence
   initial
   begin
      void'($urandom(32'h8B58));
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (int a = 8'h70; a <= 8'h78; a++)
      begin
         rd(8'(a), a == 8'h75 ? AFS_RST_LATCH : AFS_RST_STATUS);
         if (a < 8'h74)
         begin
            u_host.access(1'b1, 8'(a), 8'($urandom));
            rd(8'(a), 8'h00);
         end
      end
      rnd = 8'($urandom);
      u_host.access(1'b1, AFS_OFS_MASK, rnd);
      rd(AFS_OFS_MASK, rnd & AFS_MASK_WMASK);
      dig <= 3'($urandom);
      repeat (2) @(posedge clk_sys);
      rd(AFS_OFS_GLOB_A, {dig, 5'h00});
      dig <= 3'h0;
      for (int m = 0; m < 2; m++)
      begin
         u_host.access(1'b1, AFS_OFS_MASK, m ? 8'hF7 : 8'h00);
         u_host.access(1'b1, AFS_OFS_LATCH, m ? 8'hFF : AFS_RST_LATCH);
         for (int i = 0; i < AFS_NUM_IN; i++)
         begin
            loc = where(i);
            flt <= 18'h1 << i;
            repeat (8) @(posedge clk_sys);
            chk(8'(!(m == 0 && (i < AFS_I_L_CBCW || i >= AFS_I_DVDD_UV))), 8'(fault_report_n));
            chk(8'(!(m == 0 && i >= AFS_I_L_CBCW && i < AFS_I_DVDD_UV)), 8'(warn_report_n));
            if (i < AFS_I_DVDD_UV)
            begin
               u_host.access(1'b1, AFS_OFS_CLEAR, 8'h80);
               rd(loc[15:8], loc[7:0]);
            end
            flt <= '0;
            repeat (8) @(posedge clk_sys);
            u_host.access(1'b1, AFS_OFS_CLEAR, 8'h80);
            if (i < AFS_I_DVDD_UV)
               rd(loc[15:8], 8'h00);
         end
      end
      // latch enables low: clock fault follows its live level
      u_host.access(1'b1, AFS_OFS_LATCH, 8'h00);
      flt <= 18'h1 << AFS_I_CLK;
      repeat (8) @(posedge clk_sys);
      rd(AFS_OFS_GLOB_A, 8'h04);
      flt <= '0;
      repeat (8) @(posedge clk_sys);
      rd(AFS_OFS_GLOB_A, 8'h00);
      repeat (2) @(posedge clk_sys);
      finish_test();
   end
endmodule
